// *** src/wtc_watchdog.sv ***
// Chosen here: the register offsets and the APB register port.
`default_nettype none

// How it works
// - time-out in interrupt mode sets flag
// - vector execution or writing one clears flag
// - request needs flag, enable and global enable
// - combined mode: vector clears enable and flag
// - combined mode: unserviced second time-out resets
// - reset and interrupt enables select mode
// - clearing reset enable or select needs unlock
// - unlock bit self-clears after four cycles
// - dog reset flag forces reset enable set
// - select split at bit 5 and 2..0
// - codes 0..9 double 2048 up to 1048576
// - counter advances on watchdog oscillator cycles
// - fuse forces reset mode, enables locked
// - restart instruction clears counter to zero
module wtc_watchdog (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// processor side, same clock
	input  wire logic        cpu_irq_global_en,
	input  wire logic        vector_ack,
	input  wire logic        restart_instr,
	input  wire logic        dog_reset_flag,
	// pins from outside the clock domain
	input  wire logic        always_on_fuse,
	input  wire logic        wdt_osc_in,
	// outputs
	output logic             irq_req,
	output logic             sys_reset_req
);

	wtc_pkg::wtc_state_type q;
	wtc_pkg::wtc_state_type d;

	logic                    fuse_level;
	logic                    osc_rise;
	logic                    reset_en_eff;
	logic                    irq_en_eff;
	wtc_pkg::wtc_mode_type   mode;
	logic                    access;
	logic                    ctl_write;
	logic                    unlock_load;
	logic                    timeout;
	logic                    irq_cond;
	logic [20:0]             terminal;

	// ============================================================
	// decode and time-out functions
	function automatic wtc_pkg::wtc_reg_type reg_decode(input logic [11:0] addr);
		case (addr)
			wtc_pkg::ADDR_CONTROL: reg_decode = wtc_pkg::REG_CONTROL;
			wtc_pkg::ADDR_STATUS:  reg_decode = wtc_pkg::REG_STATUS;
			default:               reg_decode = wtc_pkg::REG_NONE;
		endcase
	endfunction : reg_decode

	// reserved codes fall back to the longest period, the safest choice
	function automatic logic [20:0] last_count(input logic [3:0] sel);
		logic [3:0] s;
		s = (sel > wtc_pkg::SEL_LAST) ? wtc_pkg::SEL_LAST : sel;
		last_count = (wtc_pkg::TIMEOUT_BASE << s) - 21'h000001;
	endfunction : last_count

	// ============================================================
	// crossings from the pins
	wtc_sync u_osc_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.async_in(wdt_osc_in),
		.level_q (),
		.rise_q  (osc_rise)
	);

	// the fuse is a static strap, but it still goes through two flops
	wtc_sync u_fuse_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.async_in(always_on_fuse),
		.level_q (fuse_level),
		.rise_q  ()
	);

	// ============================================================
	// effective mode bits
	always_comb begin
		reset_en_eff = q.reset_en | dog_reset_flag | fuse_level;
		irq_en_eff   = q.irq_en & ~fuse_level;
		mode         = wtc_pkg::wtc_mode_type'({reset_en_eff, irq_en_eff});
		if (fuse_level) begin
			mode = wtc_pkg::MODE_RESET;
		end
		terminal     = last_count(q.sel);
		access       = psel & penable & ~q.pready;
		// a write lands at the edge that completes the transfer
		ctl_write    = psel & penable & q.pready & pwrite &
			       (reg_decode(paddr) == wtc_pkg::REG_CONTROL);
		unlock_load  = ctl_write & pwdata[wtc_pkg::UNLOCK_BIT];
		// the tick comes out of the synchroniser, never from the raw pin
		timeout      = osc_rise & ~restart_instr & (mode != wtc_pkg::MODE_STOPPED) &
			       (q.count == terminal);
		irq_cond     = q.flag & irq_en_eff & cpu_irq_global_en;
	end

	// ============================================================
	// next state
	always_comb begin
		d           = q;
		d.pready    = 1'b0;
		d.pslverr   = 1'b0;
		d.sys_reset = 1'b0;

		// unlock window countdown
		if (q.unlock_cnt == 3'h1) begin
			d.unlock     = 1'b0;
			d.unlock_cnt = 3'h0;
		end else if (q.unlock_cnt != 3'h0) begin
			d.unlock_cnt = q.unlock_cnt - 3'h1;
		end

		// counter
		if (mode == wtc_pkg::MODE_STOPPED) begin
			d.count = wtc_pkg::COUNT_RESET;
		end else if (restart_instr) begin
			d.count = wtc_pkg::COUNT_RESET;
		end else if (osc_rise) begin
			if (q.count == terminal) begin
				d.count = wtc_pkg::COUNT_RESET;
			end else begin
				d.count = q.count + 21'h000001;
			end
		end

		// vector execution clears the flag, and the enable in combined mode
		if (vector_ack) begin
			d.flag = 1'b0;
			if (mode == wtc_pkg::MODE_BOTH) begin
				d.irq_en = 1'b0;
			end
		end

		// apb access: one wait state, then pready
		if (access) begin
			d.pready = 1'b1;
			case (reg_decode(paddr))
				wtc_pkg::REG_CONTROL: begin
					d.prdata = {24'h000000, q.flag, irq_en_eff, q.sel[3],
						    q.unlock, reset_en_eff, q.sel[2:0]};
				end
				wtc_pkg::REG_STATUS: begin
					d.prdata = wtc_pkg::RDATA_RESET;
					d.prdata[wtc_pkg::STATUS_MODE_LSB +: 2] = mode;
					d.prdata[20:0] = q.count;
				end
				default: begin
					d.prdata  = wtc_pkg::RDATA_RESET;
					d.pslverr = 1'b1;
				end
			endcase
		end

		if (ctl_write) begin
			if (pwdata[wtc_pkg::FLAG_BIT]) begin
				d.flag = 1'b0;
			end
			d.irq_en = pwdata[wtc_pkg::IRQ_EN_BIT];
			// setting reset enable is always taken; clearing needs the window
			if (pwdata[wtc_pkg::RESET_EN_BIT]) begin
				d.reset_en = 1'b1;
			end else if (q.unlock) begin
				d.reset_en = 1'b0;
			end
			if (q.unlock) begin
				d.sel = {pwdata[wtc_pkg::SEL_HI_BIT],
					 pwdata[wtc_pkg::SEL_LO_MSB:0]};
			end
			// a write with unlock low closes the window at once
			if (unlock_load) begin
				d.unlock     = 1'b1;
				d.unlock_cnt = wtc_pkg::UNLOCK_CYCLES;
			end else begin
				d.unlock     = 1'b0;
				d.unlock_cnt = 3'h0;
			end
		end

		// time-out action; a set beats any clear of the same cycle
		if (timeout) begin
			case (mode)
				wtc_pkg::MODE_IRQ: begin
					d.flag = 1'b1;
				end
				wtc_pkg::MODE_RESET: begin
					d.sys_reset = 1'b1;
				end
				wtc_pkg::MODE_BOTH: begin
					if (q.flag) begin
						d.sys_reset = 1'b1;
					end else begin
						d.flag = 1'b1;
					end
				end
				default: begin
					d.sys_reset = 1'b0;
				end
			endcase
		end

		// locks applied last so that no path can undo them
		if (dog_reset_flag) begin
			d.reset_en = 1'b1;
		end
		if (fuse_level) begin
			d.irq_en = 1'b0;
		end
		d.irq_req = irq_cond;
	end

	// ============================================================
	// registers
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			q            <= '0;
			q.sel        <= wtc_pkg::SEL_RESET;
			q.count      <= wtc_pkg::COUNT_RESET;
			q.prdata     <= wtc_pkg::RDATA_RESET;
		end else begin
			q <= d;
		end
	end

	assign prdata        = q.prdata;
	assign pready        = q.pready;
	assign pslverr       = q.pslverr;
	assign irq_req       = q.irq_req;
	assign sys_reset_req = q.sys_reset;

	// ============================================================
	// assertions
	flag_set_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		(timeout && mode == wtc_pkg::MODE_IRQ) |=> q.flag
	) else $error("flag not set by time-out in interrupt mode");

	flag_clear_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		(vector_ack && !timeout) |=> !q.flag
	) else $error("flag not cleared by vector execution");

	flag_write_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		(ctl_write && pwdata[wtc_pkg::FLAG_BIT] && !timeout) |=> !q.flag
	) else $error("flag not cleared by writing one");

	irq_gate_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		##1 (irq_req == $past(irq_cond))
	) else $error("interrupt request not gated by flag and enables");

	combined_ack_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		(vector_ack && mode == wtc_pkg::MODE_BOTH && !ctl_write) |=> !q.irq_en
	) else $error("combined mode vector did not clear enable");

	combined_reset_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		(timeout && mode == wtc_pkg::MODE_BOTH && q.flag) |=> sys_reset_req
	) else $error("unserviced second time-out did not reset");

	stopped_idle_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		(!reset_en_eff && !irq_en_eff && !fuse_level) |=> (q.count == 21'h000000) && !sys_reset_req
	) else $error("stopped mode still counting");

	locked_select_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		(ctl_write && !q.unlock) |=> (q.sel == $past(q.sel))
	) else $error("select changed without unlock");

	unlock_load_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		unlock_load ##1 (!ctl_write) [*3] |=> q.unlock
	) else $error("unlock window shorter than four cycles");

	unlock_expire_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		(q.unlock_cnt == 3'h1 && !ctl_write) |=> !q.unlock
	) else $error("unlock did not clear after four cycles");

	dog_flag_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		dog_reset_flag |=> q.reset_en
	) else $error("reset enable not forced by dog reset flag");

	select_terminal_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		timeout |-> (q.count == terminal) && (terminal[10:0] == 11'h7FF)
	) else $error("time-out at wrong count");

	osc_step_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		(!osc_rise && !restart_instr && mode != wtc_pkg::MODE_STOPPED)
			|=> (q.count == $past(q.count))
	) else $error("counter moved without an oscillator cycle");

	fuse_lock_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		fuse_level |-> (mode == wtc_pkg::MODE_RESET) && reset_en_eff && !irq_en_eff
	) else $error("fuse did not force reset mode");

	restart_zero_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		restart_instr |=> (q.count == 21'h000000)
	) else $error("restart did not clear the counter");

	reset_pulse_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		(timeout && mode == wtc_pkg::MODE_RESET) |=> sys_reset_req ##1 !sys_reset_req
	) else $error("reset request not a one-cycle pulse");

	synced_event_a: assert property (
		@(posedge clk) disable iff (!reset_n)
		timeout |-> osc_rise
	) else $error("time-out without synchronised oscillator edge");

endmodule : wtc_watchdog

`default_nettype wire

// *** src/wtc_pkg.sv ***
`default_nettype none

package wtc_pkg;

	// ============================================================
	// register map (byte addresses on the APB)
	localparam logic [11:0] ADDR_CONTROL    = 12'h000;
	localparam logic [11:0] ADDR_STATUS     = 12'h004;

	// ============================================================
	// control register field positions
	localparam int          FLAG_BIT        = 7;
	localparam int          IRQ_EN_BIT      = 6;
	localparam int          SEL_HI_BIT      = 5;
	localparam int          UNLOCK_BIT      = 4;
	localparam int          RESET_EN_BIT    = 3;
	localparam int          SEL_LO_MSB      = 2;

	// status register field positions
	localparam int          STATUS_MODE_LSB = 24;

	// ============================================================
	// reset values
	localparam logic [3:0]  SEL_RESET       = 4'h0;
	localparam logic [20:0] COUNT_RESET     = 21'h000000;
	localparam logic [31:0] RDATA_RESET     = 32'h00000000;

	// ============================================================
	// timing
	localparam logic [2:0]  UNLOCK_CYCLES   = 3'h4;
	localparam logic [20:0] TIMEOUT_BASE    = 21'h000800;
	localparam logic [3:0]  SEL_LAST        = 4'h9;

	// ============================================================
	// modes and register decode
	typedef enum logic [1:0] {
		MODE_STOPPED = 2'b00,
		MODE_IRQ     = 2'b01,
		MODE_RESET   = 2'b10,
		MODE_BOTH    = 2'b11
	} wtc_mode_type;

	typedef enum logic [1:0] {
		REG_CONTROL = 2'b00,
		REG_STATUS  = 2'b01,
		REG_NONE    = 2'b11
	} wtc_reg_type;

	// ============================================================
	// state carriers
	typedef struct packed {
		logic        meta;
		logic        level;
		logic        last;
		logic        rise;
	} wtc_sync_state_type;

	typedef struct packed {
		logic        flag;
		logic        irq_en;
		logic        unlock;
		logic [2:0]  unlock_cnt;
		logic        reset_en;
		logic [3:0]  sel;
		logic [20:0] count;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        irq_req;
		logic        sys_reset;
	} wtc_state_type;

endpackage : wtc_pkg

`default_nettype wire

// *** src/wtc_sync.sv ***
`default_nettype none

// two-flop synchroniser with a registered rising-edge pulse
module wtc_sync (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// asynchronous level in
	input  wire logic async_in,
	// synchronised outputs
	output logic      level_q,
	output logic      rise_q
);

	wtc_pkg::wtc_sync_state_type q;
	wtc_pkg::wtc_sync_state_type d;

	// ============================================================
	// next state
	always_comb begin
		d = q;
		// meta is read by the level flop only
		d.meta  = async_in;
		d.level = q.meta;
		d.last  = q.level;
		d.rise  = q.level & ~q.last;
	end

	// ============================================================
	// registers
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign level_q = q.level;
	assign rise_q  = q.rise;

endmodule : wtc_sync

`default_nettype wire

// *** tb/tb.sv ***
`default_nettype none

`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin num_errors++; \
	$display("Error %s expected %0h seen %0h", nm, ex, gt); end end

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ============================================================
	// signals
	logic        clk;
	logic        reset_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        cpu_irq_global_en;
	logic        vector_ack;
	logic        restart_instr;
	logic        dog_reset_flag;
	logic        always_on_fuse;
	logic        wdt_osc_in;
	logic        irq_req;
	logic        sys_reset_req;
	logic [33:0] note_q[$];
	logic [33:0] note;
	logic [3:0]  sel_now;
	int          num_errors;
	int          samples_checked;
	int          resets_seen;
	int          cycles;
	localparam logic [11:0] CTRL = wtc_pkg::ADDR_CONTROL;
	localparam logic [11:0] STAT = wtc_pkg::ADDR_STATUS;

	wtc_watchdog dut_u (
		.clk               (clk),
		.reset_n           (reset_n),
		.psel              (psel),
		.penable           (penable),
		.pwrite            (pwrite),
		.paddr             (paddr),
		.pwdata            (pwdata),
		.prdata            (prdata),
		.pready            (pready),
		.pslverr           (pslverr),
		.cpu_irq_global_en (cpu_irq_global_en),
		.vector_ack        (vector_ack),
		.restart_instr     (restart_instr),
		.dog_reset_flag    (dog_reset_flag),
		.always_on_fuse    (always_on_fuse),
		.wdt_osc_in        (wdt_osc_in),
		.irq_req           (irq_req),
		.sys_reset_req     (sys_reset_req)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ============================================================
	// helpers
	function automatic logic [31:0] ctl(input logic f, ie, u, re, input logic [3:0] s);
		return {24'h000000, f, ie, s[3], u, re, s[2:0]};
	endfunction : ctl

	task test_done();
		if (num_errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done

	// starts at a rising edge; keep leaves psel up for a back-to-back setup
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [33:0] ex, input logic keep);
		note_q.push_back(ex);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		if (!keep) begin
			psel    <= 1'b0;
			penable <= 1'b0;
			@(posedge clk);
		end
	endtask : apb

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 34'h000000000, 1'b0);
	endtask : wr

	task rd(input logic [11:0] a, input logic [31:0] ex);
		apb(1'b0, a, 32'h00000000, {2'b10, ex}, 1'b0);
	endtask : rd

	// unlock, then the new value in the very next transfer
	task change(input logic [3:0] s, input logic re);
		pulse(1'b0);
		apb(1'b1, CTRL, ctl(1'b0, 1'b0, 1'b1, 1'b1, sel_now), 34'h000000000, 1'b1);
		apb(1'b1, CTRL, {24'($urandom), 8'h00} | ctl(1'b0, 1'b0, 1'b0, re, s),
			34'h000000000, 1'b0);
		sel_now = s;
	endtask : change

	task pulse(input logic vec);
		vector_ack    <= vec;
		restart_instr <= !vec;
		@(posedge clk);
		vector_ack    <= 1'b0;
		restart_instr <= 1'b0;
		@(posedge clk);
	endtask : pulse

	// each tick is a rising edge of the oscillator; slack lets the synchroniser settle
	task ticks(input int n);
		repeat (n) begin
			wdt_osc_in <= 1'b1;
			repeat (2) @(posedge clk);
			wdt_osc_in <= 1'b0;
			repeat (2) @(posedge clk);
		end
		repeat (6) @(posedge clk);
	endtask : ticks

	// ============================================================
	// monitor: answers are matched against the oldest note
	always @(posedge clk) begin
		if (reset_n && sys_reset_req === 1'b1)
			resets_seen++;
		if (psel && penable && pready === 1'b1) begin
			if (note_q.size() == 0)
				`CHK("unexpected answer", 1'b0, 1'b1)
			else begin
				note = note_q.pop_front();
				`CHK("pslverr", note[32], pslverr)
				if (note[33])
					`CHK("prdata", note[31:0], prdata)
			end
		end
		cycles++;
		if (cycles == 80000) begin
			num_errors++;
			test_done();
		end
	end

	// ============================================================
	// main sequence
	initial begin
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		cpu_irq_global_en = 1'b0;
		vector_ack = 1'b0;
		restart_instr = 1'b0;
		dog_reset_flag = 1'b0;
		always_on_fuse = 1'b0;
		wdt_osc_in = 1'b0;
		sel_now = 4'h0;
		void'($urandom(81426));
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		rd(CTRL, ctl(1'b0, 1'b0, 1'b0, 1'b0, 4'h0));
		rd(STAT, 32'h00000000);
		apb(1'b0, 12'h008, 32'h00000000, {2'b11, 32'h00000000}, 1'b0);
		repeat (3) begin
			change(4'($urandom_range(9, 0)), 1'b1);
			rd(CTRL, ctl(1'b0, 1'b0, 1'b0, 1'b1, sel_now));
		end
		wr(CTRL, ctl(1'b0, 1'b0, 1'b0, 1'b0, sel_now ^ 4'h1));
		rd(CTRL, ctl(1'b0, 1'b0, 1'b0, 1'b1, sel_now));
		apb(1'b1, CTRL, ctl(1'b0, 1'b0, 1'b1, 1'b1, sel_now), 34'h000000000, 1'b1);
		apb(1'b0, CTRL, 32'h00000000, {2'b10, ctl(1'b0, 1'b0, 1'b1, 1'b1, sel_now)}, 1'b0);
		repeat (5) @(posedge clk);
		rd(CTRL, ctl(1'b0, 1'b0, 1'b0, 1'b1, sel_now));
		change(4'h0, 1'b0);
		rd(CTRL, ctl(1'b0, 1'b0, 1'b0, 1'b0, 4'h0));
		dog_reset_flag <= 1'b1;
		@(posedge clk);
		rd(CTRL, ctl(1'b0, 1'b0, 1'b0, 1'b1, 4'h0));
		dog_reset_flag <= 1'b0;
		change(4'h0, 1'b0);
		rd(CTRL, ctl(1'b0, 1'b0, 1'b0, 1'b0, 4'h0));
		ticks(50);
		rd(STAT, 32'h00000000);
		// interrupt mode, global enable held off at first
		wr(CTRL, ctl(1'b0, 1'b1, 1'b0, 1'b0, 4'h0));
		pulse(1'b0);
		ticks(2047);
		rd(CTRL, ctl(1'b0, 1'b1, 1'b0, 1'b0, 4'h0));
		ticks(1);
		rd(CTRL, ctl(1'b1, 1'b1, 1'b0, 1'b0, 4'h0));
		`CHK("irq_req", 1'b0, irq_req)
		cpu_irq_global_en <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK("irq_req", 1'b1, irq_req)
		rd(STAT, 32'h01000000);
		pulse(1'b1);
		@(posedge clk);
		`CHK("irq_req", 1'b0, irq_req)
		rd(CTRL, ctl(1'b0, 1'b1, 1'b0, 1'b0, 4'h0));
		ticks(2048);
		wr(CTRL, ctl(1'b1, 1'b1, 1'b0, 1'b0, 4'h0));
		rd(CTRL, ctl(1'b0, 1'b1, 1'b0, 1'b0, 4'h0));
		ticks(100);
		rd(STAT, 32'h01000064);
		pulse(1'b0);
		rd(STAT, 32'h01000000);
		`CHK("resets", 0, resets_seen)
		// reset mode
		wr(CTRL, ctl(1'b0, 1'b0, 1'b0, 1'b1, 4'h0));
		pulse(1'b0);
		ticks(2048);
		`CHK("resets", 1, resets_seen)
		rd(CTRL, ctl(1'b0, 1'b0, 1'b0, 1'b1, 4'h0));
		rd(STAT, 32'h02000000);
		// interrupt then reset mode
		wr(CTRL, ctl(1'b0, 1'b1, 1'b0, 1'b1, 4'h0));
		pulse(1'b0);
		ticks(2048);
		`CHK("resets", 1, resets_seen)
		rd(STAT, 32'h03000000);
		rd(CTRL, ctl(1'b1, 1'b1, 1'b0, 1'b1, 4'h0));
		pulse(1'b1);
		rd(CTRL, ctl(1'b0, 1'b0, 1'b0, 1'b1, 4'h0));
		wr(CTRL, ctl(1'b0, 1'b1, 1'b0, 1'b1, 4'h0));
		pulse(1'b0);
		ticks(2048);
		rd(CTRL, ctl(1'b1, 1'b1, 1'b0, 1'b1, 4'h0));
		ticks(2048);
		`CHK("resets", 2, resets_seen)
		// fuse programmed
		always_on_fuse <= 1'b1;
		pulse(1'b0);
		repeat (4) @(posedge clk);
		wr(CTRL, ctl(1'b1, 1'b1, 1'b0, 1'b0, 4'h0));
		rd(CTRL, ctl(1'b0, 1'b0, 1'b0, 1'b1, 4'h0));
		rd(STAT, 32'h02000000);
		ticks(2048);
		`CHK("resets", 3, resets_seen)
		`CHK("notes left", 0, note_q.size())
		test_done();
	end

endmodule : tb

`undef CHK

`default_nettype wire
